// ===== src/wsc_wake_regs.sv
// Function
// - second cyclic timer wakes only while internal wake bit 7 is one.
// - first cyclic timer wakes only while internal wake bit 6 is one.
// - reserved bits of these registers always read zero.
// - internal bit 2 disables watchdog in stop mode; hardware may update it.
// - global bit zero: only wakes raise interrupt; one: all status bits.
// - measurement select excludes wake inputs one and two, ignoring their enables.
// - measurement select enables the measurement function during normal mode.
// - external bits 2..0 enable wake inputs three, two, one.
// - transceiver mode 01 means wake capable, acting as wake source.
// - fail-safe entry forces bus control and external wake patterns.
// - power-on or soft reset loads external register with 0000 0111.
// - restart keeps external register's defined bits, reserved bits zero.
// - each wake input has two-bit pull: none, down, up, automatic.
// - power-on or soft reset clears internal and pull registers.
`include "wsc_cfg.svh"

module wsc_wake_regs #(
    parameter int ADDR_W     = 7,
    parameter int NUM_INPUTS = 3
) (
    // clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    nrst_i,
    // reset causes and device mode
    input  wire logic                    soft_rst_i,
    input  wire logic                    restart_i,
    input  wire logic                    failsafe_entry_i,
    input  wire logic                    normal_mode_i,
    // register access from the serial frame decoder
    input  wire logic                    reg_we_i,
    input  wire logic [ADDR_W-1:0]       reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    output logic [7:0]                   reg_rdata_o,
    // hardware update of the watchdog stop bit
    input  wire logic                    wd_stop_hw_we_i,
    input  wire logic                    wd_stop_hw_val_i,
    // wake and status events
    input  wire logic [NUM_INPUTS-1:0]   input_evt_i,
    input  wire logic                    timer_a_evt_i,
    input  wire logic                    timer_b_evt_i,
    input  wire logic [2:0]              xcvr_evt_i,
    input  wire logic                    status_evt_i,
    // transceiver mode fields (can, lin one, lin two)
    input  wire wsc_pkg::wsc_xcvr_mode_t can_mode_i,
    input  wire wsc_pkg::wsc_xcvr_mode_t lin_a_mode_i,
    input  wire wsc_pkg::wsc_xcvr_mode_t lin_b_mode_i,
    // controls towards the rest of the chip
    output logic                         wake_req_o,
    output logic                         int_req_o,
    output logic                         watchdog_stop_disable_hi_o,
    output logic                         measurement_active_o,
    output logic [2*NUM_INPUTS-1:0]      wake_input_pull_o,
    // fail-safe force of the bus control registers
    output logic                         bus_force_o,
    output logic [7:0]                   bus_a_keep_o,
    output logic [7:0]                   bus_a_set_o,
    output logic [7:0]                   bus_b_keep_o,
    output logic [7:0]                   bus_b_set_o
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the bank decodes registers up to 0x08 and has exactly three inputs
    if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr
        $error("wsc_wake_regs: ADDR_W must be 4 to 8");
    end
    if (NUM_INPUTS != 3) begin : g_bad_inputs
        $error("wsc_wake_regs: NUM_INPUTS must be 3");
    end

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0] int_wake_q;
    logic [7:0] int_wake_d;
    logic [7:0] ext_wake_q;
    logic [7:0] ext_wake_d;
    logic [7:0] pull_q;
    logic [7:0] pull_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       wake_req_q;
    logic       int_req_q;
    logic       meas_act_q;
    logic       bus_force_q;

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire [7:0] addr_ext = 8'(reg_addr_i);
    wire       sel_int  = (addr_ext == 8'(`WSC_ADDR_INT_WAKE));
    wire       sel_ext  = (addr_ext == 8'(`WSC_ADDR_EXT_WAKE));
    wire       sel_pull = (addr_ext == 8'(`WSC_ADDR_PULL));
    wire       wr_int   = reg_we_i && sel_int;
    wire       wr_ext   = reg_we_i && sel_ext;
    wire       wr_pull  = reg_we_i && sel_pull;

    // ****************************************************************
    // field views
    // ****************************************************************
    wire cyclic_timer_b_wake_enable = int_wake_q[`WSC_BIT_TIMER_B_EN];
    wire cyclic_timer_a_wake_enable = int_wake_q[`WSC_BIT_TIMER_A_EN];
    wire watchdog_stop_disable_hi   = int_wake_q[`WSC_BIT_WD_STOP_HI];
    wire global_interrupt_scope     = ext_wake_q[`WSC_BIT_INT_GLOBAL];
    wire measurement_select         = ext_wake_q[`WSC_BIT_MEAS_SEL];
    wire [NUM_INPUTS-1:0] wake_input_enable =
        ext_wake_q[`WSC_LSB_INPUT_EN +: NUM_INPUTS];

    // ****************************************************************
    // next value of the internal wake register
    // ****************************************************************
    // priority: soft reset, restart, hardware bit update over software write;
    // hardware wins on bit 2 so a watchdog event is never lost to a write
    always_comb begin
        int_wake_d = int_wake_q;
        if (soft_rst_i) begin
            int_wake_d = `WSC_RST_INT_WAKE;
        end else if (restart_i) begin
            int_wake_d = int_wake_q & `WSC_KEEP_INT_WAKE;
        end else begin
            if (wr_int) begin
                int_wake_d = reg_wdata_i & `WSC_MASK_INT_WAKE;
            end
            if (wd_stop_hw_we_i) begin
                int_wake_d[`WSC_BIT_WD_STOP_HI] = wd_stop_hw_val_i;
            end
        end
    end

    // ****************************************************************
    // next value of the external wake register
    // ****************************************************************
    // fail-safe outranks a software write in the same cycle
    always_comb begin
        ext_wake_d = ext_wake_q;
        if (soft_rst_i) begin
            ext_wake_d = `WSC_RST_EXT_WAKE;
        end else if (failsafe_entry_i) begin
            ext_wake_d = (ext_wake_q & `WSC_FS_KEEP_EXT_WAKE)
                       | `WSC_FS_SET_EXT_WAKE;
        end else if (restart_i) begin
            ext_wake_d = ext_wake_q & `WSC_KEEP_EXT_WAKE;
        end else if (wr_ext) begin
            ext_wake_d = reg_wdata_i & `WSC_MASK_EXT_WAKE;
        end
    end

    // ****************************************************************
    // next value of the pull register
    // ****************************************************************
    always_comb begin
        pull_d = pull_q;
        if (soft_rst_i) begin
            pull_d = `WSC_RST_PULL;
        end else if (restart_i) begin
            pull_d = pull_q & `WSC_KEEP_PULL;
        end else if (wr_pull) begin
            pull_d = reg_wdata_i & `WSC_MASK_PULL;
        end
    end

    // ****************************************************************
    // read data, registered one cycle after the address
    // ****************************************************************
    // unmapped addresses read zero
    always_comb begin
        if (sel_int) begin
            rdata_d = int_wake_q;
        end else if (sel_ext) begin
            rdata_d = ext_wake_q;
        end else if (sel_pull) begin
            rdata_d = pull_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    // ****************************************************************
    // wake and interrupt merge
    // ****************************************************************
    logic                    wake_any;
    logic                    int_any;
    wsc_pkg::wsc_xcvr_mode_t xcvr_mode [3];

    // transceiver wake is chosen only through these mode fields
    assign xcvr_mode[0] = can_mode_i;
    assign xcvr_mode[1] = lin_a_mode_i;
    assign xcvr_mode[2] = lin_b_mode_i;

    wsc_wake_combine #(
        .NUM_INPUTS (NUM_INPUTS),
        .NUM_XCVR   (3)
    ) u_combine (
        .input_en_i    (wake_input_enable),
        .timer_a_en_i  (cyclic_timer_a_wake_enable),
        .timer_b_en_i  (cyclic_timer_b_wake_enable),
        .meas_sel_i    (measurement_select),
        .int_global_i  (global_interrupt_scope),
        .xcvr_mode_i   (xcvr_mode),
        .input_evt_i   (input_evt_i),
        .timer_a_evt_i (timer_a_evt_i),
        .timer_b_evt_i (timer_b_evt_i),
        .xcvr_evt_i    (xcvr_evt_i),
        .status_evt_i  (status_evt_i),
        .wake_any_o    (wake_any),
        .int_any_o     (int_any)
    );

    // measurement runs only in normal mode with the select bit set
    wire meas_act_d = measurement_select && normal_mode_i;

    // ****************************************************************
    // registers
    // ****************************************************************
    // configuration registers
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            int_wake_q <= `WSC_RST_INT_WAKE;
            ext_wake_q <= `WSC_RST_EXT_WAKE;
            pull_q     <= `WSC_RST_PULL;
        end else begin
            int_wake_q <= int_wake_d;
            ext_wake_q <= ext_wake_d;
            pull_q     <= pull_d;
        end
    end

    // status and strobe outputs
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rdata_q     <= 8'h00;
            wake_req_q  <= 1'b0;
            int_req_q   <= 1'b0;
            meas_act_q  <= 1'b0;
            bus_force_q <= 1'b0;
        end else begin
            rdata_q     <= rdata_d;
            wake_req_q  <= wake_any;
            int_req_q   <= int_any;
            meas_act_q  <= meas_act_d;
            bus_force_q <= failsafe_entry_i && !soft_rst_i;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // patterns are constants, the force strobe is the timed part
    assign reg_rdata_o                = rdata_q;
    assign wake_req_o                 = wake_req_q;
    assign int_req_o                  = int_req_q;
    assign watchdog_stop_disable_hi_o = watchdog_stop_disable_hi;
    assign measurement_active_o       = meas_act_q;
    assign wake_input_pull_o          = pull_q[`WSC_LSB_PULL +: 2*NUM_INPUTS];
    assign bus_force_o                = bus_force_q;
    assign bus_a_keep_o               = `WSC_FS_KEEP_BUS_A;
    assign bus_a_set_o                = `WSC_FS_SET_BUS_A;
    assign bus_b_keep_o               = `WSC_FS_KEEP_BUS_B;
    assign bus_b_set_o                = `WSC_FS_SET_BUS_B;

endmodule : wsc_wake_regs

// ===== src/wsc_cfg.svh
`ifndef WSC_CFG_SVH
`define WSC_CFG_SVH

// ****************************************************************
// register addresses (7-bit register address of the serial frame)
// ****************************************************************
`define WSC_ADDR_INT_WAKE      7'h06
`define WSC_ADDR_EXT_WAKE      7'h07
`define WSC_ADDR_PULL          7'h08

// ****************************************************************
// reset values after power-on or soft reset
// ****************************************************************
`define WSC_RST_INT_WAKE       8'h00
`define WSC_RST_EXT_WAKE       8'h07
`define WSC_RST_PULL           8'h00

// ****************************************************************
// writable bits of each register, reserved bits read as zero
// ****************************************************************
`define WSC_MASK_INT_WAKE      8'hC4
`define WSC_MASK_EXT_WAKE      8'hA7
`define WSC_MASK_PULL          8'h3F

// ****************************************************************
// bits kept on restart, all others cleared
// ****************************************************************
`define WSC_KEEP_INT_WAKE      8'h04
`define WSC_KEEP_EXT_WAKE      8'hA7
`define WSC_KEEP_PULL          8'h3F

// ****************************************************************
// fail-safe patterns: keep mask and forced ones
// ****************************************************************
`define WSC_FS_KEEP_EXT_WAKE   8'hA0
`define WSC_FS_SET_EXT_WAKE    8'h07
`define WSC_FS_KEEP_BUS_A      8'hE0
`define WSC_FS_SET_BUS_A       8'h09
`define WSC_FS_KEEP_BUS_B      8'h00
`define WSC_FS_SET_BUS_B       8'h01

// ****************************************************************
// field positions
// ****************************************************************
`define WSC_BIT_TIMER_B_EN     7
`define WSC_BIT_TIMER_A_EN     6
`define WSC_BIT_WD_STOP_HI     2
`define WSC_BIT_INT_GLOBAL     7
`define WSC_BIT_MEAS_SEL       5
`define WSC_LSB_INPUT_EN       0
`define WSC_LSB_PULL           0

`endif

// ===== src/wsc_pkg.sv
// ****************************************************************
// shared types of the wake source control bank
// ****************************************************************
package wsc_pkg;

    // pull resistor setting of one wake input
    typedef enum logic [1:0] {
        WSC_PULL_NONE = 2'h0,
        WSC_PULL_DOWN = 2'h1,
        WSC_PULL_UP   = 2'h2,
        WSC_PULL_AUTO = 2'h3
    } wsc_pull_t;

    // transceiver mode field
    typedef enum logic [1:0] {
        WSC_XCVR_OFF    = 2'h0,
        WSC_XCVR_WAKE   = 2'h1,
        WSC_XCVR_RXONLY = 2'h2,
        WSC_XCVR_NORMAL = 2'h3
    } wsc_xcvr_mode_t;

endpackage : wsc_pkg

// ===== src/wsc_wake_combine.sv
// ****************************************************************
// gates each wake source with its enable and merges them
// ****************************************************************
module wsc_wake_combine #(
    parameter int NUM_INPUTS = 3,
    parameter int NUM_XCVR   = 3
) (
    // enables
    input  wire logic [NUM_INPUTS-1:0]   input_en_i,
    input  wire logic                    timer_a_en_i,
    input  wire logic                    timer_b_en_i,
    input  wire logic                    meas_sel_i,
    input  wire logic                    int_global_i,
    input  wire wsc_pkg::wsc_xcvr_mode_t xcvr_mode_i [NUM_XCVR],
    // events
    input  wire logic [NUM_INPUTS-1:0]   input_evt_i,
    input  wire logic                    timer_a_evt_i,
    input  wire logic                    timer_b_evt_i,
    input  wire logic [NUM_XCVR-1:0]     xcvr_evt_i,
    input  wire logic                    status_evt_i,
    // merged results
    output logic                         wake_any_o,
    output logic                         int_any_o
);

    logic [NUM_INPUTS-1:0] input_hit;
    logic [NUM_XCVR-1:0]   xcvr_hit;

    // first two inputs are masked while measuring
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_input
        wire masked = meas_sel_i && (i < 2);
        assign input_hit[i] = input_evt_i[i] && input_en_i[i] && !masked;
    end

    // a transceiver wakes only in its wake-capable mode
    for (genvar j = 0; j < NUM_XCVR; j++) begin : g_xcvr
        assign xcvr_hit[j] = xcvr_evt_i[j] && (xcvr_mode_i[j] == wsc_pkg::WSC_XCVR_WAKE);
    end

    // or of every enabled source
    assign wake_any_o = (|input_hit) || (|xcvr_hit)
                      || (timer_a_evt_i && timer_a_en_i)
                      || (timer_b_evt_i && timer_b_en_i);

    // other status only reaches the interrupt in global scope
    assign int_any_o = wake_any_o || (int_global_i && status_evt_i);

endmodule : wsc_wake_combine

// ===== testbench/wsc_wake_regs_props.sv
`include "wsc_cfg.svh"

// ****************************************************************
// port checker of the wake source control bank
// ****************************************************************
module wsc_wake_regs_props #(
    parameter int ADDR_W     = 7,
    parameter int NUM_INPUTS = 3
) (
    // clock and reset
    input wire logic                  clk_sys_i,
    input wire logic                  nrst_i,
    // causes and access
    input wire logic                  soft_rst_i,
    input wire logic                  restart_i,
    input wire logic                  failsafe_entry_i,
    input wire logic                  normal_mode_i,
    input wire logic                  reg_we_i,
    input wire logic [ADDR_W-1:0]     reg_addr_i,
    input wire logic [7:0]            reg_wdata_i,
    input wire logic [NUM_INPUTS-1:0] input_evt_i,
    input wire logic                  timer_a_evt_i,
    input wire logic                  timer_b_evt_i,
    input wire logic [2:0]            xcvr_evt_i,
    input wire logic                  status_evt_i,
    // watched outputs
    input wire logic [7:0]            reg_rdata_o,
    input wire logic                  wake_req_o,
    input wire logic                  int_req_o,
    input wire logic                  measurement_active_o,
    input wire logic                  bus_force_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // no wake source fires this cycle
    wire no_evt = !(|input_evt_i) && !timer_a_evt_i && !timer_b_evt_i && !(|xcvr_evt_i);

    a_unmapped_zero: assert property (!(reg_addr_i inside {7'h06, 7'h07, 7'h08}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_int_reserved: assert property (reg_addr_i == 7'h06 |=> (reg_rdata_o & 8'h3B) == 8'h00)
        else $error("internal reserved bits set");
    a_ext_reserved: assert property (reg_addr_i == 7'h07 |=> (reg_rdata_o & 8'h58) == 8'h00)
        else $error("external reserved bits set");
    a_pull_write_back: assert property ((reg_we_i && reg_addr_i == 7'h08 && !soft_rst_i && !restart_i)
        ##1 (reg_addr_i == 7'h08 && !reg_we_i && !soft_rst_i)
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h3F))
        else $error("pull write not read back");
    a_soft_ext_value: assert property (soft_rst_i ##1 (reg_addr_i == 7'h07 && !reg_we_i)
        |=> reg_rdata_o == 8'h07)
        else $error("external value after soft reset");
    a_meas_needs_normal: assert property (!normal_mode_i |=> !measurement_active_o)
        else $error("measurement active outside normal mode");
    a_force_follows: assert property (failsafe_entry_i && !soft_rst_i |=> bus_force_o)
        else $error("bus force missing after fail-safe entry");
    a_force_only_fs: assert property (!failsafe_entry_i |=> !bus_force_o)
        else $error("bus force without fail-safe entry");
    a_wake_needs_evt: assert property (no_evt |=> !wake_req_o)
        else $error("wake without event");
    a_wake_sets_int: assert property (wake_req_o |-> int_req_o)
        else $error("wake without interrupt");
    a_int_needs_cause: assert property (no_evt && !status_evt_i |=> !int_req_o)
        else $error("interrupt without cause");

    // main scenarios reached
    c_wake: cover property (wake_req_o);
    c_status_int: cover property (int_req_o && !wake_req_o);
    c_force: cover property (bus_force_o);
endmodule : wsc_wake_regs_props
bind wsc_wake_regs wsc_wake_regs_props #(.ADDR_W(ADDR_W), .NUM_INPUTS(NUM_INPUTS)) u_props (
    .clk_sys_i, .nrst_i, .soft_rst_i, .restart_i, .failsafe_entry_i, .normal_mode_i, .reg_we_i,
    .reg_addr_i, .reg_wdata_i, .input_evt_i, .timer_a_evt_i, .timer_b_evt_i, .xcvr_evt_i,
    .status_evt_i, .reg_rdata_o, .wake_req_o, .int_req_o, .measurement_active_o, .bus_force_o);

// ===== testbench/wsc_host_model.sv
// ****************************************************************
// host controller: register frames and transceiver mode fields
// ****************************************************************
module wsc_host_model (
    // clock and read data
    input  wire logic               clk_i,
    input  wire logic [7:0]         rdata_i,
    // register access
    output logic                    we_o,
    output logic [6:0]              addr_o,
    output logic [7:0]              wdata_o,
    // transceiver mode fields
    output wsc_pkg::wsc_xcvr_mode_t can_o,
    output wsc_pkg::wsc_xcvr_mode_t lin_a_o,
    output wsc_pkg::wsc_xcvr_mode_t lin_b_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus, all transceivers off
    initial begin
        we_o = 1'b0;
        addr_o = 7'h00;
        wdata_o = 8'h00;
        can_o = wsc_pkg::WSC_XCVR_OFF;
        lin_a_o = wsc_pkg::WSC_XCVR_OFF;
        lin_b_o = wsc_pkg::WSC_XCVR_OFF;
    end

    // one cycle strobe, taken at the second edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        we_o <= 1'b0;
    endtask : wr

    // read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask : rd

    // bus wake sources are chosen only through the mode fields
    task automatic modes(input wsc_pkg::wsc_xcvr_mode_t c, input wsc_pkg::wsc_xcvr_mode_t a,
                         input wsc_pkg::wsc_xcvr_mode_t b);
        @(posedge clk_i);
        can_o <= c;
        lin_a_o <= a;
        lin_b_o <= b;
    endtask : modes
endmodule : wsc_host_model

// ===== testbench/wsc_wake_regs_bench.sv
// ****************************************************************
// register and wake path tests
// ****************************************************************
module wsc_wake_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, soft_rst_i = 1'b0, restart_i = 1'b0;
    logic failsafe_entry_i = 1'b0, normal_mode_i = 1'b0, wd_stop_hw_we_i = 1'b0;
    logic wd_stop_hw_val_i = 1'b1, timer_a_evt_i = 1'b0, timer_b_evt_i = 1'b0, status_evt_i = 1'b0;
    logic [2:0] input_evt_i = 3'h0, xcvr_evt_i = 3'h0;
    logic reg_we_i, wake_req_o, int_req_o, watchdog_stop_disable_hi_o, measurement_active_o, bus_force_o;
    logic [6:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, bus_a_keep_o, bus_a_set_o, bus_b_keep_o, bus_b_set_o;
    logic [5:0] wake_input_pull_o;
    wsc_pkg::wsc_xcvr_mode_t can_mode_i, lin_a_mode_i, lin_b_mode_i;
    int failures = 0, cmp_count = 0, cyc = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    wsc_host_model u_wsc_host_model (.clk_i(clk_sys_i), .rdata_i(reg_rdata_o), .we_o(reg_we_i),
        .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .can_o(can_mode_i), .lin_a_o(lin_a_mode_i),
        .lin_b_o(lin_b_mode_i));

    wsc_wake_regs u_wsc_wake_regs (.clk_sys_i, .nrst_i, .soft_rst_i, .restart_i, .failsafe_entry_i,
        .normal_mode_i, .reg_we_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .wd_stop_hw_we_i,
        .wd_stop_hw_val_i, .input_evt_i, .timer_a_evt_i, .timer_b_evt_i, .xcvr_evt_i, .status_evt_i,
        .can_mode_i, .lin_a_mode_i, .lin_b_mode_i, .wake_req_o, .int_req_o, .watchdog_stop_disable_hi_o,
        .measurement_active_o, .wake_input_pull_o, .bus_force_o, .bus_a_keep_o, .bus_a_set_o,
        .bus_b_keep_o, .bus_b_set_o);

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    // the run needs under 1000 cycles
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [6:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        u_wsc_host_model.rd(a, d);
        chk(n, e, d);
    endtask : rchk

    // one cycle of events; e holds the expected wake and interrupt flags
    task automatic ev(input logic [2:0] i, input logic [2:0] x, input logic a, input logic b,
                      input logic s, input logic [1:0] e, input string n);
        @(posedge clk_sys_i);
        {input_evt_i, xcvr_evt_i, timer_a_evt_i, timer_b_evt_i, status_evt_i} <= {i, x, a, b, s};
        @(posedge clk_sys_i);
        {input_evt_i, xcvr_evt_i, timer_a_evt_i, timer_b_evt_i, status_evt_i} <= 9'h000;
        #1 chk(n, {6'h00, e}, {6'h00, wake_req_o, int_req_o});
    endtask : ev

    initial begin
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rchk(7'h06, 8'h00, "internal reset");
        rchk(7'h07, 8'h07, "external reset");
        rchk(7'h08, 8'h00, "pull reset");
        $display("test reset values done");
        for (int i = 6; i < 10; i++) u_wsc_host_model.wr(i[6:0], 8'hFF);
        rchk(7'h06, 8'hC4, "internal ones");
        rchk(7'h07, 8'hA7, "external ones");
        rchk(7'h08, 8'h3F, "pull ones");
        rchk(7'h09, 8'h00, "unmapped");
        for (int k = 0; k < 4; k++) begin
            u_wsc_host_model.wr(7'h08, {2'h0, k[1:0], k[1:0], k[1:0]});
            #1 chk("pull out", {2'h0, k[1:0], k[1:0], k[1:0]}, {2'h0, wake_input_pull_o});
        end
        $display("test reserved and pull done");
        @(posedge clk_sys_i);
        wd_stop_hw_we_i <= 1'b1;
        u_wsc_host_model.wr(7'h06, 8'h00);
        wd_stop_hw_we_i <= 1'b0;
        #1 chk("watchdog hw wins", 8'h01, {7'h00, watchdog_stop_disable_hi_o});
        u_wsc_host_model.wr(7'h06, 8'h00);
        #1 chk("watchdog sw", 8'h00, {7'h00, watchdog_stop_disable_hi_o});
        $display("test watchdog bit done");
        u_wsc_host_model.wr(7'h06, 8'h00);
        u_wsc_host_model.wr(7'h07, 8'h07);
        ev(3'h0, 3'h0, 1'b1, 1'b0, 1'b0, 2'b00, "timer a off");
        ev(3'h0, 3'h0, 1'b0, 1'b1, 1'b0, 2'b00, "timer b off");
        u_wsc_host_model.wr(7'h06, 8'h40);
        ev(3'h0, 3'h0, 1'b1, 1'b0, 1'b0, 2'b11, "timer a on");
        ev(3'h0, 3'h0, 1'b0, 1'b1, 1'b0, 2'b00, "timer b still off");
        u_wsc_host_model.wr(7'h06, 8'h80);
        ev(3'h0, 3'h0, 1'b0, 1'b1, 1'b0, 2'b11, "timer b on");
        ev(3'h0, 3'h0, 1'b1, 1'b0, 1'b0, 2'b00, "timer a off again");
        for (int i = 0; i < 3; i++) ev(3'h1 << i, 3'h0, 1'b0, 1'b0, 1'b0, 2'b11, "input on");
        u_wsc_host_model.wr(7'h07, 8'h05);
        ev(3'h2, 3'h0, 1'b0, 1'b0, 1'b0, 2'b00, "input b off");
        ev(3'h5, 3'h0, 1'b0, 1'b0, 1'b0, 2'b11, "inputs a c on");
        u_wsc_host_model.wr(7'h07, 8'h27);
        ev(3'h3, 3'h0, 1'b0, 1'b0, 1'b0, 2'b00, "measuring masks a b");
        ev(3'h4, 3'h0, 1'b0, 1'b0, 1'b0, 2'b11, "measuring keeps c");
        @(posedge clk_sys_i) normal_mode_i <= 1'b1;
        @(posedge clk_sys_i);
        #1 chk("measurement active", 8'h01, {7'h00, measurement_active_o});
        ev(3'h0, 3'h0, 1'b0, 1'b0, 1'b1, 2'b00, "status local");
        u_wsc_host_model.wr(7'h07, 8'h87);
        ev(3'h0, 3'h0, 1'b0, 1'b0, 1'b1, 2'b01, "status global");
        u_wsc_host_model.modes(wsc_pkg::WSC_XCVR_WAKE, wsc_pkg::WSC_XCVR_NORMAL, wsc_pkg::WSC_XCVR_RXONLY);
        ev(3'h0, 3'h1, 1'b0, 1'b0, 1'b0, 2'b11, "can wake");
        ev(3'h0, 3'h6, 1'b0, 1'b0, 1'b0, 2'b00, "lin not wake");
        $display("test wake sources done");
        u_wsc_host_model.wr(7'h06, 8'hC4);
        u_wsc_host_model.wr(7'h07, 8'hA5);
        u_wsc_host_model.wr(7'h08, 8'h2A);
        @(posedge clk_sys_i) restart_i <= 1'b1;
        @(posedge clk_sys_i) restart_i <= 1'b0;
        rchk(7'h06, 8'h04, "internal restart");
        rchk(7'h07, 8'hA5, "external restart");
        rchk(7'h08, 8'h2A, "pull restart");
        $display("test restart done");
        u_wsc_host_model.wr(7'h07, 8'hA0);
        @(posedge clk_sys_i) failsafe_entry_i <= 1'b1;
        @(posedge clk_sys_i) failsafe_entry_i <= 1'b0;
        #1 chk("bus force", 8'h01, {7'h00, bus_force_o});
        chk("bus a pattern", 8'hE9, {bus_a_keep_o[7:4], bus_a_set_o[3:0]});
        chk("bus b pattern", 8'h01, bus_b_keep_o | bus_b_set_o);
        rchk(7'h07, 8'hA7, "external fail-safe");
        $display("test fail-safe done");
        @(posedge clk_sys_i) soft_rst_i <= 1'b1;
        @(posedge clk_sys_i) soft_rst_i <= 1'b0;
        rchk(7'h06, 8'h00, "internal soft");
        rchk(7'h07, 8'h07, "external soft");
        rchk(7'h08, 8'h00, "pull soft");
        $display("test soft reset done");
        end_of_test();
    end
endmodule : wsc_wake_regs_bench
